// file: core/ufc_regs.vh
// register map, field positions and reset values of the usb function control block
`ifndef UFC_REGS_VH
`define UFC_REGS_VH
// ----------------------------------------
// bus-visible word offsets
// ----------------------------------------
`define UFC_BUS_IADDR 12'h000
`define UFC_BUS_IDATA 12'h004
`define UFC_BUS_EMCFG 12'h008
`define UFC_WIN_LO 12'h400
`define UFC_WIN_HI 12'h7ff
`define UFC_EMCFG_FAE 0
// ----------------------------------------
// indirect register addresses
// ----------------------------------------
`define UFC_R_FUNCTION_ADDRESS_REG 8'h00
`define UFC_R_POWER 8'h01
`define UFC_R_INFLG 8'h02
`define UFC_R_OUTFLG 8'h04
`define UFC_R_CMFLG 8'h06
`define UFC_R_INEN 8'h07
`define UFC_R_OUTEN 8'h09
`define UFC_R_CMEN 8'h0b
`define UFC_R_INDEX 8'h0e
`define UFC_R_CSR0 8'h11
`define UFC_R_INCSRH 8'h12
`define UFC_R_OUTCSRL 8'h14
`define UFC_R_OUTCSRH 8'h15
`define UFC_R_FIFO0 8'h20
`define UFC_R_FIFO3 8'h23
// ----------------------------------------
// power register fields
// ----------------------------------------
`define UFC_PW_SUSPEND_DETECT_ENABLE 0
`define UFC_PW_SUSP 1
`define UFC_PW_RESUME 2
`define UFC_PW_RST 3
`define UFC_PW_INH 4
`define UFC_PW_ISO_UPDATE_ENABLE 7
// ----------------------------------------
// other fields and reset values
// ----------------------------------------
`define UFC_FA_UPDATE 7
`define UFC_INH_SPLIT 2
`define UFC_INH_ISO 6
`define UFC_INL_INRDY 0
`define UFC_CM_SUSP 0
`define UFC_CM_RES 1
`define UFC_CM_RST 2
`define UFC_CM_SOF 3
`define UFC_INEN_RST 8'h0f
`define UFC_OUTEN_RST 8'h0e
`define UFC_CMEN_RST 8'h06
`define UFC_CMEN_NOSUS 8'h0e
`define UFC_RESP_OK 2'b00
`define UFC_RESP_ERR 2'b10
`endif

// file: core/ufc_fifo_ram.v
// dual-port byte memory holding all endpoint fifos, registered read on both ports
`timescale 1ns/1ps
module ufc_fifo_ram #(
  parameter AW = 10
) (
  input wire mclk_i,
  input wire [AW-1:0] a_addr_i,
  input wire a_we_i,
  input wire [7:0] a_wdata_i,
  output reg [7:0] a_rdata_o,
  input wire [AW-1:0] b_addr_i,
  input wire b_we_i,
  input wire [7:0] b_wdata_i,
  output reg [7:0] b_rdata_o
);
  reg [7:0] mem [0:(1<<AW)-1];
  // ----------------------------------------
  // port a: processor, port b: serial engine
  // ----------------------------------------
  // one process owns the array; on a same-address clash the engine write lands
  always @(posedge mclk_i) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (b_we_i) begin
      mem[b_addr_i] <= b_wdata_i;
    end
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end
endmodule

// file: core/ufc_top.v
// usb function control: axi4-lite slave, indirect registers, fifo access, reset/suspend/irq
`timescale 1ns/1ps
`include "ufc_regs.vh"
module ufc_top #(
  parameter AW = 10
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sie_bus_reset_i,
  input wire sie_suspend_i,
  input wire sie_resume_i,
  input wire sie_sof_i,
  input wire sie_xfer_end_i,
  input wire [3:0] sie_in_done_i,
  input wire [3:0] sie_out_done_i,
  input wire sie_pkt_err_i,
  input wire sie_in_token_i,
  input wire [1:0] sie_token_ep_i,
  input wire [AW-1:0] sie_ram_addr_i,
  input wire sie_ram_we_i,
  input wire [7:0] sie_ram_wdata_i,
  output wire [7:0] sie_ram_rdata_o,
  output wire [6:0] function_address_o,
  output wire suspended_o,
  output wire resume_signal_o,
  output reg osc_wake_o,
  output wire iso_zero_len_o,
  output wire [3:0] iso_hold_o,
  output wire function_inhibit_o,
  output wire usb_irq_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg soft_rst;
  wire usb_rst_n;
  reg [7:0] indirect_address_reg;
  reg [7:0] ext_memory_config;
  reg [6:0] addr_new;
  reg [6:0] addr_live;
  reg addr_update;
  reg suspend_detect_enable;
  reg suspended;
  reg resume_ctl;
  reg function_inhibit;
  reg iso_update_enable;
  reg [7:0] in_irq_flags;
  reg [7:0] out_irq_flags;
  reg [7:0] common_irq_flags;
  reg [7:0] in_irq_enables;
  reg [7:0] out_irq_enables;
  reg [7:0] common_irq_enables;
  reg [1:0] ep_index;
  reg [7:0] csr_lo [0:3];
  reg [7:0] in_csr_hi [0:3];
  reg [7:0] out_csr_lo [0:3];
  reg [7:0] out_csr_hi [0:3];
  reg [8:0] rd_ptr [0:3];
  reg [8:0] wr_ptr [0:3];
  reg [3:0] iso_pend;
  reg [11:0] rd_addr;
  reg rd_p1;
  reg rd_p2;
  reg [7:0] reg_val;
  reg [7:0] ram_addr;
  wire [7:0] ram_q;
  wire [AW-1:0] ram_a;
  integer i;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte address of a fifo slot: segment base, upper half for in when split
  function [AW-1:0] fifo_addr;
    input [1:0] ep;
    input [8:0] ptr;
    input half_in;
    input split;
    reg [AW-1:0] base;
    reg [AW-1:0] size;
    begin
      size = {{(AW-1){1'b0}}, 1'b1} << ({1'b0, ep} + 3'd2); // 3 bits so ep3 does not wrap
      size = size << 4;
      base = size - {{(AW-7){1'b0}}, 7'h40};
      if (split) begin
        size = size >> 1;
      end
      fifo_addr = base + ((split & half_in) ? size : {AW{1'b0}}) + ({1'b0, ptr} & (size - 1'b1));
    end
  endfunction
  function in_win;
    input [11:0] a;
    begin
      in_win = (a >= `UFC_WIN_LO) && (a <= `UFC_WIN_HI);
    end
  endfunction
  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~rd_p1 & ~rd_p2;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~s_axi_rvalid & ~rd_p1 & ~rd_p2 & ~wr_go;
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire fae = ext_memory_config[`UFC_EMCFG_FAE];
  wire wr_lo = s_axi_wstrb[0];
  wire wr_win = wr_go & in_win(s_axi_awaddr) & fae;
  wire wr_data = wr_go & (s_axi_awaddr == `UFC_BUS_IDATA) & wr_lo;
  wire wr_fifo = wr_data & (indirect_address_reg >= `UFC_R_FIFO0) & (indirect_address_reg <= `UFC_R_FIFO3);
  wire [1:0] wf_ep = indirect_address_reg[1:0];
  wire rd_data = rd_p2 & (rd_addr == `UFC_BUS_IDATA);
  wire rd_fifo = rd_data & (indirect_address_reg >= `UFC_R_FIFO0) & (indirect_address_reg <= `UFC_R_FIFO3);
  wire rd_win = in_win(rd_addr) & fae;
  wire [7:0] w8 = s_axi_wdata[7:0];
  wire wr_power = wr_data & (indirect_address_reg == `UFC_R_POWER);
  wire wr_function_address_reg = wr_data & (indirect_address_reg == `UFC_R_FUNCTION_ADDRESS_REG);
  // ----------------------------------------
  // soft usb reset, one cycle, async to the usb registers
  // ----------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_power & w8[`UFC_PW_RST];
    end
  end
  assign usb_rst_n = reset_n_i & ~soft_rst;
  // ----------------------------------------
  // memory port a address: direct window or endpoint fifo
  // ----------------------------------------
  assign ram_a = wr_win ? s_axi_awaddr[AW-1:0] :
                 wr_fifo ? fifo_addr(wf_ep, wr_ptr[wf_ep], 1'b1, in_csr_hi[wf_ep][`UFC_INH_SPLIT]) :
                 (rd_addr == `UFC_BUS_IDATA) ?
                   fifo_addr(wf_ep, rd_ptr[wf_ep], 1'b0, in_csr_hi[wf_ep][`UFC_INH_SPLIT]) :
                 rd_addr[AW-1:0];
  ufc_fifo_ram #(
    .AW(AW)
  ) u_ram (
    .mclk_i(mclk_i),
    .a_addr_i(ram_a),
    .a_we_i(wr_win | wr_fifo),
    .a_wdata_i(w8),
    .a_rdata_o(ram_q),
    .b_addr_i(sie_ram_addr_i),
    .b_we_i(sie_ram_we_i),
    .b_wdata_i(sie_ram_wdata_i),
    .b_rdata_o(sie_ram_rdata_o)
  );
  // ----------------------------------------
  // indirect read value
  // ----------------------------------------
  always @* begin
    ram_addr = indirect_address_reg;
    case (ram_addr)
      `UFC_R_FUNCTION_ADDRESS_REG: reg_val = {addr_update, addr_new};
      `UFC_R_POWER: reg_val = {iso_update_enable, 2'b00, function_inhibit, 1'b0, resume_ctl, suspended,
                               suspend_detect_enable};
      `UFC_R_INFLG: reg_val = in_irq_flags;
      `UFC_R_OUTFLG: reg_val = out_irq_flags;
      `UFC_R_CMFLG: reg_val = common_irq_flags;
      `UFC_R_INEN: reg_val = in_irq_enables;
      `UFC_R_OUTEN: reg_val = out_irq_enables;
      `UFC_R_CMEN: reg_val = common_irq_enables;
      `UFC_R_INDEX: reg_val = {6'h00, ep_index};
      `UFC_R_CSR0: reg_val = csr_lo[ep_index];
      `UFC_R_INCSRH: reg_val = in_csr_hi[ep_index];
      `UFC_R_OUTCSRL: reg_val = out_csr_lo[ep_index];
      `UFC_R_OUTCSRH: reg_val = out_csr_hi[ep_index];
      default: reg_val = 8'h00;
    endcase
  end
  // ----------------------------------------
  // bus-side registers and responses, three cycles from read acceptance to rvalid
  // ----------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      indirect_address_reg <= 8'h00;
      ext_memory_config <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UFC_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `UFC_RESP_OK;
      s_axi_rdata <= 32'h00000000;
      rd_addr <= 12'h000;
      rd_p1 <= 1'b0;
      rd_p2 <= 1'b0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `UFC_RESP_OK;
        if (s_axi_awaddr == `UFC_BUS_IADDR) begin
          if (wr_lo) begin
            indirect_address_reg <= w8;
          end
        end else if (s_axi_awaddr == `UFC_BUS_EMCFG) begin
          if (wr_lo) begin
            ext_memory_config <= w8;
          end
        end else if (!(wr_win || s_axi_awaddr == `UFC_BUS_IDATA)) begin
          s_axi_bresp <= `UFC_RESP_ERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        rd_addr <= s_axi_araddr;
      end
      rd_p1 <= rd_go;
      rd_p2 <= rd_p1;
      if (rd_p2) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `UFC_RESP_OK;
        s_axi_rdata <= 32'h00000000;
        if (rd_addr == `UFC_BUS_IADDR) begin
          s_axi_rdata[7:0] <= indirect_address_reg;
        end else if (rd_addr == `UFC_BUS_EMCFG) begin
          s_axi_rdata[7:0] <= ext_memory_config;
        end else if (rd_fifo || rd_win) begin
          s_axi_rdata[7:0] <= ram_q;
        end else if (rd_data) begin
          s_axi_rdata[7:0] <= reg_val;
        end else begin
          s_axi_rresp <= `UFC_RESP_ERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // usb function registers
  // ----------------------------------------
  wire rd_clr = rd_data;
  wire [3:0] in_ok = sie_in_done_i & {4{~sie_pkt_err_i}};
  wire [3:0] out_ok = sie_out_done_i & {4{~sie_pkt_err_i}};
  wire go_susp = suspend_detect_enable & sie_suspend_i & ~suspended;
  wire set_resume = wr_power & w8[`UFC_PW_RESUME];
  wire leave_susp = suspended & (sie_resume_i | set_resume | sie_bus_reset_i);
  always @(posedge mclk_i or negedge usb_rst_n) begin
    if (!usb_rst_n) begin
      addr_new <= 7'h00;
      addr_live <= 7'h00;
      addr_update <= 1'b0;
      suspend_detect_enable <= 1'b0;
      suspended <= 1'b0;
      resume_ctl <= 1'b0;
      function_inhibit <= 1'b1;
      iso_update_enable <= 1'b0;
      in_irq_flags <= 8'h00;
      out_irq_flags <= 8'h00;
      common_irq_flags <= 8'h00;
      in_irq_enables <= `UFC_INEN_RST;
      out_irq_enables <= `UFC_OUTEN_RST;
      common_irq_enables <= `UFC_CMEN_RST;
      ep_index <= 2'b00;
      iso_pend <= 4'h0;
      osc_wake_o <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        csr_lo[i] <= 8'h00;
        in_csr_hi[i] <= 8'h00;
        out_csr_lo[i] <= 8'h00;
        out_csr_hi[i] <= 8'h00;
        rd_ptr[i] <= 9'h000;
        wr_ptr[i] <= 9'h000;
      end
    end else begin
      osc_wake_o <= leave_susp;
      // register writes through the data port
      if (wr_data) begin
        case (indirect_address_reg)
          `UFC_R_FUNCTION_ADDRESS_REG: begin
            addr_new <= w8[6:0];
            addr_update <= 1'b1;
          end
          `UFC_R_POWER: begin
            suspend_detect_enable <= w8[`UFC_PW_SUSPEND_DETECT_ENABLE];
            resume_ctl <= w8[`UFC_PW_RESUME];
            iso_update_enable <= w8[`UFC_PW_ISO_UPDATE_ENABLE];
            if (!w8[`UFC_PW_INH]) begin
              function_inhibit <= 1'b0;
            end
          end
          `UFC_R_INEN: in_irq_enables <= w8;
          `UFC_R_OUTEN: out_irq_enables <= w8;
          `UFC_R_CMEN: common_irq_enables <= w8;
          `UFC_R_INDEX: ep_index <= w8[1:0];
          `UFC_R_CSR0: begin
            csr_lo[ep_index] <= w8;
            if (w8[`UFC_INL_INRDY] && in_csr_hi[ep_index][`UFC_INH_ISO] && iso_update_enable) begin
              iso_pend[ep_index] <= 1'b1;
            end
          end
          `UFC_R_INCSRH: in_csr_hi[ep_index] <= w8;
          `UFC_R_OUTCSRL: out_csr_lo[ep_index] <= w8;
          `UFC_R_OUTCSRH: out_csr_hi[ep_index] <= w8;
          default: begin
          end
        endcase
      end
      // fifo pointers move one byte per access
      if (wr_fifo) begin
        wr_ptr[wf_ep] <= wr_ptr[wf_ep] + 9'h001;
      end
      if (rd_fifo) begin
        rd_ptr[wf_ep] <= rd_ptr[wf_ep] + 9'h001;
      end
      // new address becomes live when the transfer ends; a write in that cycle stays pending
      if (sie_xfer_end_i && addr_update && !wr_function_address_reg) begin
        addr_live <= addr_new;
        addr_update <= 1'b0;
      end
      if (sie_sof_i) begin
        iso_pend <= 4'h0;
      end
      // suspend and resume
      if (go_susp) begin
        suspended <= 1'b1;
      end else if (leave_susp) begin
        suspended <= 1'b0;
      end
      // read clears a flag register; a new event in the same cycle survives
      if (rd_clr && indirect_address_reg == `UFC_R_INFLG) begin
        in_irq_flags <= {4'h0, in_ok};
      end else begin
        in_irq_flags <= in_irq_flags | {4'h0, in_ok};
      end
      if (rd_clr && indirect_address_reg == `UFC_R_OUTFLG) begin
        out_irq_flags <= {4'h0, out_ok[3:1], 1'b0};
      end else begin
        out_irq_flags <= out_irq_flags | {4'h0, out_ok[3:1], 1'b0};
      end
      if (rd_clr && indirect_address_reg == `UFC_R_CMFLG) begin
        common_irq_flags <= {4'h0, sie_sof_i, 1'b0, sie_resume_i & suspended, go_susp};
      end else begin
        common_irq_flags <= common_irq_flags |
          {4'h0, sie_sof_i, 1'b0, sie_resume_i & suspended, go_susp};
      end
      // bus reset: address, fifos, csrs, index, enables and flags
      if (sie_bus_reset_i) begin
        addr_new <= 7'h00;
        addr_live <= 7'h00;
        addr_update <= 1'b0;
        ep_index <= 2'b00;
        iso_pend <= 4'h0;
        in_irq_enables <= `UFC_INEN_RST;
        out_irq_enables <= `UFC_OUTEN_RST;
        common_irq_enables <= (common_irq_enables & 8'h01) | `UFC_CMEN_NOSUS;
        in_irq_flags <= 8'h00;
        out_irq_flags <= 8'h00;
        common_irq_flags <= 8'h04;
        for (i = 0; i < 4; i = i + 1) begin
          csr_lo[i] <= 8'h00;
          in_csr_hi[i] <= 8'h00;
          out_csr_lo[i] <= 8'h00;
          out_csr_hi[i] <= 8'h00;
          rd_ptr[i] <= 9'h000;
          wr_ptr[i] <= 9'h000;
        end
      end
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign function_address_o = addr_live;
  assign suspended_o = suspended;
  assign resume_signal_o = resume_ctl;
  assign function_inhibit_o = function_inhibit;
  assign iso_hold_o = iso_pend;
  assign iso_zero_len_o = sie_in_token_i & iso_pend[sie_token_ep_i];
  // any enabled flag drives the interrupt
  assign usb_irq_o = |((in_irq_flags & in_irq_enables) | (out_irq_flags & out_irq_enables) |
                       (common_irq_flags & common_irq_enables));
endmodule

// file: sim/ufc_chk.sv
// assertions on the ports of the usb function control block
`timescale 1ns/1ps
module ufc_chk (
  input wire mclk_i,
  input wire reset_n_i,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  input wire sie_bus_reset_i,
  input wire sie_resume_i,
  input wire sie_sof_i,
  input wire sie_xfer_end_i,
  input wire sie_in_token_i,
  input wire [1:0] sie_token_ep_i,
  input wire [6:0] function_address_o,
  input wire suspended_o,
  input wire osc_wake_o,
  input wire iso_zero_len_o,
  input wire [3:0] iso_hold_o,
  input wire function_inhibit_o,
  input wire usb_irq_o
);
  // --------
  // port relations
  // --------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  // read request accepted by the slave
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // bus reset seen while suspended
  sequence s_rst_susp;
    sie_bus_reset_i && suspended_o;
  endsequence
  a_rd_latency: assert property (s_rd_taken |-> ##3 s_axi_rvalid)
    else $error("read answer late");
  a_rst_addr: assert property (sie_bus_reset_i |-> ##[1:3] function_address_o == 7'h00)
    else $error("address kept over bus reset");
  a_rst_irq: assert property (sie_bus_reset_i |-> ##[1:3] usb_irq_o)
    else $error("no interrupt after bus reset");
  a_rst_wake: assert property (s_rst_susp |-> ##[1:3] !suspended_o)
    else $error("bus reset kept suspend");
  a_res_exit: assert property (sie_resume_i && suspended_o |-> ##[1:3] !suspended_o)
    else $error("resume kept suspend");
  a_wake_pulse: assert property ($fell(suspended_o) |-> ##[0:1] osc_wake_o ##1 !osc_wake_o)
    else $error("oscillator wake pulse wrong");
  a_zero_len: assert property (iso_zero_len_o |-> sie_in_token_i && iso_hold_o[sie_token_ep_i])
    else $error("zero length without held endpoint");
  a_sof_clr: assert property (sie_sof_i |=> iso_hold_o == 4'h0)
    else $error("held packet kept over frame start");
  a_addr_live: assert property
    (!$stable(function_address_o) |-> $past(sie_xfer_end_i) || function_address_o == 7'h00)
    else $error("address changed mid transfer");
  a_inh_set: assert property
    ($rose(function_inhibit_o) |-> s_axi_bvalid)
    else $error("inhibit set without soft reset");
endmodule

bind ufc_top ufc_chk i_chk (.mclk_i, .reset_n_i, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .sie_bus_reset_i, .sie_resume_i, .sie_sof_i, .sie_xfer_end_i, .sie_in_token_i, .sie_token_ep_i,
  .function_address_o, .suspended_o, .osc_wake_o, .iso_zero_len_o, .iso_hold_o, .function_inhibit_o, .usb_irq_o);

// file: sim/ufc_host_model.sv
// serial engine stand-in turning bench requests into bus event pulses
`timescale 1ns/1ps
module ufc_host_model (
  input wire mclk_i,
  input wire go_i,
  input wire [3:0] ev_i,
  input wire [3:0] ep_i,
  input wire err_i,
  input wire [9:0] adr_i,
  input wire [7:0] dat_i,
  output reg [7:0] pulse_o,
  output reg [3:0] in_done_o,
  output reg [3:0] out_done_o,
  output reg [1:0] token_ep_o,
  output reg [9:0] ram_addr_o,
  output reg [7:0] ram_wdata_o
);
  // --------
  // event pulses
  // --------
  initial begin
    pulse_o = 8'h00;
    in_done_o = 4'h0;
    out_done_o = 4'h0;
    token_ep_o = 2'h0;
    ram_addr_o = 10'h000;
    ram_wdata_o = 8'h00;
  end
  // each request becomes a one-cycle pulse at the next edge
  always @(posedge mclk_i) begin
    pulse_o <= 8'h00;
    in_done_o <= 4'h0;
    out_done_o <= 4'h0;
    ram_addr_o <= adr_i;
    ram_wdata_o <= ~ram_wdata_o; // idle data line toggles
    if (go_i && ev_i < 4'h5) begin
      pulse_o <= 8'h01 << ev_i; // reset, suspend, resume, frame start, transfer end
    end
    if (go_i && ev_i == 4'h5) begin
      in_done_o <= ep_i; // only once the host acknowledged
    end
    if (go_i && ev_i == 4'h6) begin
      out_done_o <= ep_i; // complete packet received
      pulse_o[5] <= err_i; // corruption flagged in the same cycle
    end
    if (go_i && ev_i == 4'h7) begin
      pulse_o[6] <= 1'b1;
      token_ep_o <= ep_i[1:0];
    end
    if (go_i && ev_i == 4'h8) begin
      pulse_o[7] <= 1'b1;
      ram_wdata_o <= dat_i;
    end
  end
endmodule

// file: sim/ufc_tb.sv
// self-checking bench for the usb function control block
`timescale 1ns/1ps
`include "ufc_regs.vh"
module testbench;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, sie_in_done_i, sie_out_done_i, iso_hold_o, ep = 4'h0, ev = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, suspended_o, resume_signal_o;
  logic osc_wake_o, iso_zero_len_o, function_inhibit_o, usb_irq_o, go = 1'b0, err = 1'b0, zl;
  logic sie_bus_reset_i, sie_suspend_i, sie_resume_i, sie_sof_i, sie_xfer_end_i, sie_pkt_err_i, sie_in_token_i;
  logic [1:0] s_axi_bresp, s_axi_rresp, sie_token_ep_i;
  logic sie_ram_we_i;
  logic [7:0] pls, sie_ram_wdata_i, sie_ram_rdata_o, dat = 8'h00, rnd = 8'h29, q[$];
  logic [9:0] sie_ram_addr_i, adr = 10'h000;
  logic [6:0] function_address_o;
  integer errors = 0;
  integer checked = 0;
  integer i;
  // --------
  // design and engine model
  // --------
  ufc_top i_dut (.*);
  ufc_host_model i_host (.mclk_i(mclk_i), .go_i(go), .ev_i(ev), .ep_i(ep), .err_i(err), .adr_i(adr), .dat_i(dat),
    .pulse_o(pls), .in_done_o(sie_in_done_i), .out_done_o(sie_out_done_i), .token_ep_o(sie_token_ep_i),
    .ram_addr_o(sie_ram_addr_i), .ram_wdata_o(sie_ram_wdata_i));
  // unpack the engine event pulses
  assign {sie_ram_we_i, sie_in_token_i, sie_pkt_err_i, sie_xfer_end_i, sie_sof_i, sie_resume_i, sie_suspend_i,
    sie_bus_reset_i} = pls;
  // 100 mhz clock
  always #5 mclk_i = ~mclk_i;
  // random byte source
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // compare and count
  task automatic chk(input string n, input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic test_done;
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // bounded wait for a handshake: 0 write taken, 1 bvalid, 2 arready, 3 rvalid
  task automatic hs(input integer k);
    integer n;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk_i);
      if (k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid : k == 2 ? s_axi_arready : s_axi_rvalid)
        return;
    end
    chk("handshake", 0, 1);
    test_done;
  endtask
  // axi write of one byte
  task automatic axw(input [11:0] a, input [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hs(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    hs(1);
    chk("bresp", s_axi_bresp, `UFC_RESP_OK);
  endtask
  // axi read with response code
  task automatic axr(input [11:0] a, output [31:0] d, output [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hs(2);
    s_axi_arvalid <= 1'b0;
    hs(3);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // indirect register write and checked read
  task automatic wreg(input [7:0] a, input [7:0] d);
    axw(`UFC_BUS_IADDR, a);
    axw(`UFC_BUS_IDATA, d);
  endtask
  task automatic creg(input string n, input [7:0] a, input [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axw(`UFC_BUS_IADDR, a);
    axr(`UFC_BUS_IDATA, d, r);
    chk(n, d, {24'h0, e});
  endtask
  // engine event, zero-length flag sampled while the pulse stands
  task automatic evt(input [3:0] c, input [3:0] m, input e);
    ev <= c;
    ep <= m;
    err <= e;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    @(posedge mclk_i);
    zl = iso_zero_len_o;
    repeat (3) @(posedge mclk_i);
  endtask
  // engine-side memory read
  task automatic ram(input string n, input [9:0] a, input [7:0] e);
    adr <= a;
    repeat (3) @(posedge mclk_i);
    chk(n, sie_ram_rdata_o, e);
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [6:0] fa;
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    chk("inhibit", function_inhibit_o, 1);
    wreg(`UFC_R_POWER, 8'h18);
    creg("power", `UFC_R_POWER, 8'h10);
    creg("cm_en", `UFC_R_CMEN, `UFC_CMEN_RST);
    axr(12'h00c, d, r);
    chk("unmapped", r, `UFC_RESP_ERR);
    axr(`UFC_WIN_LO, d, r);
    chk("win_off", r, `UFC_RESP_ERR);
    rnd = lfsr(rnd);
    fa = rnd[6:0];
    wreg(`UFC_R_FUNCTION_ADDRESS_REG, {1'b0, fa});
    creg("addr_pend", `UFC_R_FUNCTION_ADDRESS_REG, {1'b1, fa});
    chk("addr_old", function_address_o, 0);
    evt(4'h4, 4'h0, 1'b0);
    chk("addr_live", function_address_o, fa);
    creg("addr_done", `UFC_R_FUNCTION_ADDRESS_REG, {1'b0, fa});
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      q.push_back(rnd);
      wreg(`UFC_R_FIFO3, rnd);
    end
    ram("ep3_ram", 10'd448, q[0]);
    for (i = 0; i < 4; i++) begin
      creg("ep3_pop", `UFC_R_FIFO3, q.pop_front());
    end
    wreg(`UFC_R_INDEX, 8'h01);
    wreg(`UFC_R_INCSRH, 8'h04);
    rnd = lfsr(rnd);
    wreg(8'h21, rnd);
    ram("split_in", 10'd128, rnd);
    dat <= ~rnd;
    adr <= 10'd64;
    evt(4'h8, 4'h0, 1'b0);
    creg("split_out", 8'h21, ~rnd);
    axw(`UFC_BUS_EMCFG, 8'h01);
    rnd = lfsr(rnd);
    axw(12'h7c0, rnd);
    axr(12'h7c0, d, r);
    chk("win_data", d, {24'h0, rnd});
    ram("win_ram", 10'd960, rnd);
    axr(12'h480, d, r);
    chk("win_fifo", d, {24'h0, ~dat});
    evt(4'h5, 4'h4, 1'b0);
    chk("irq_in", usb_irq_o, 1);
    creg("in_flags", `UFC_R_INFLG, 8'h04);
    creg("in_clear", `UFC_R_INFLG, 8'h00);
    chk("irq_off", usb_irq_o, 0);
    evt(4'h6, 4'h8, 1'b1);
    evt(4'h6, 4'h2, 1'b0);
    creg("out_flags", `UFC_R_OUTFLG, 8'h02);
    wreg(`UFC_R_POWER, 8'h01);
    chk("inh_clr", function_inhibit_o, 0);
    wreg(`UFC_R_POWER, 8'h11);
    chk("inh_stay", function_inhibit_o, 0);
    wreg(`UFC_R_CMEN, 8'h0f);
    evt(4'h1, 4'h0, 1'b0);
    chk("susp", suspended_o, 1);
    chk("susp_irq", usb_irq_o, 1);
    evt(4'h2, 4'h0, 1'b0);
    chk("resumed", suspended_o, 0);
    creg("cm_flags", `UFC_R_CMFLG, 8'h03);
    wreg(`UFC_R_POWER, 8'h05);
    chk("resume_on", resume_signal_o, 1);
    wreg(`UFC_R_POWER, 8'h01);
    chk("resume_off", resume_signal_o, 0);
    wreg(`UFC_R_INCSRH, 8'h40);
    wreg(`UFC_R_POWER, 8'h81);
    wreg(`UFC_R_CSR0, 8'h01);
    chk("iso_hold", iso_hold_o, 4'h2);
    evt(4'h7, 4'h1, 1'b0);
    chk("zero_len", zl, 1);
    evt(4'h3, 4'h0, 1'b0);
    chk("iso_sof", iso_hold_o, 4'h0);
    evt(4'h1, 4'h0, 1'b0);
    evt(4'h0, 4'h0, 1'b0);
    chk("rst_wake", suspended_o, 0);
    chk("rst_addr", function_address_o, 0);
    creg("rst_flags", `UFC_R_CMFLG, 8'h04);
    creg("rst_en", `UFC_R_CMEN, `UFC_CMEN_NOSUS | 8'h01);
    creg("rst_index", `UFC_R_INDEX, 8'h00);
    chk("irq_clr", usb_irq_o, 0);
    wreg(`UFC_R_POWER, 8'h08);
    repeat (3) @(posedge mclk_i);
    chk("soft_inh", function_inhibit_o, 1);
    creg("soft_en", `UFC_R_CMEN, `UFC_CMEN_RST);
    test_done;
  end
endmodule
